// file: src/npic_pkg.sv
// Package with constants and types of the nested priority interrupt controller
// Function
// - Four software priority levels allow a higher request to preempt a lower routine.
// - At most sixteen vectors, each tied to its source by hardware.
// - Vectors sit from FFE0h to FFFFh, ordered by hardware priority.
// - Reset, trap and the top-level pin event are all non-maskable; the pin event ignores level.
// - Current level is held in condition code bits 5 and 3.
// - Service starts only after the current instruction completes.
// - Maskable entry stacks program counter, index, accumulator and condition code.
// - After stacking, level bits load from the serviced vector's priority field.
// - Program counter then loads the vector; first handler fetch is from there.
// - Return from handler pops context including level bits, resuming previous level.
// - Level codes: main 10, level1 01, level2 00, level3 11 disables maskables.
// - Arbitration first picks the highest software priority.
// - Among equal software priority the highest hardware priority wins.
// - Unserviced requests stay pending until their combined priority is highest.
// - Hardware priorities are unique so exactly one winner results.
// - Reset, trap and top-level pin event win as highest software priority.
// - Maskable request taken only if enabled and above current level.
// - Non-maskables ignore level, stack except reset, load vector, set level 3.
// - Writing the level-0 code into a priority field leaves that field unchanged.
// - All priority registers reset to all ones, every vector at level 3.
package npic_pkg;
   localparam int          NUM_SRC        = 13;
   localparam logic [15:0] VEC_BASE       = 16'hFFE0;
   localparam logic [15:0] VEC_TLI        = 16'hFFFA;
   localparam logic [15:0] VEC_TRAP       = 16'hFFFC;
   localparam logic [15:0] VEC_RESET      = 16'hFFFE;
   localparam logic [15:0] VEC_SRC0       = 16'hFFF8;
   localparam int          CC_BIT_HIGH    = 5;
   localparam int          CC_BIT_LOW     = 3;
   localparam logic [1:0]  CODE_L0        = 2'h2;
   localparam logic [1:0]  CODE_L1        = 2'h1;
   localparam logic [1:0]  CODE_L2        = 2'h0;
   localparam logic [1:0]  CODE_L3        = 2'h3;
   localparam logic [7:0]  PRIO_RESET     = 8'hFF;
   localparam logic [3:0]  IDX_RESET      = 4'hF;
   localparam logic [3:0]  IDX_TRAP       = 4'hE;
   localparam logic [3:0]  IDX_TLI        = 4'hD;
   localparam logic [3:0]  IDX_NONE       = 4'h0;
   localparam logic [1:0]  ADDR_PRIO0     = 2'h0;
   localparam logic [7:0]  CC_RESET       = 8'hEA;

   typedef enum logic [2:0] {
      NPIC_IDLE,
      NPIC_STACK,
      NPIC_LEVEL,
      NPIC_VECTOR,
      NPIC_RETURN
   } npic_state_type;

   // Numeric rank of a level code, main lowest
   function automatic logic [1:0] rank(input logic [1:0] code);
      unique case (code)
         CODE_L0: rank = 2'h0;
         CODE_L1: rank = 2'h1;
         CODE_L2: rank = 2'h2;
         CODE_L3: rank = 2'h3;
      endcase
   endfunction
endpackage

// file: src/npic_ctrl.sv
// Nested priority interrupt controller top module
`timescale 1ns/1ns
module npic_ctrl (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [1:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [12:0] src_req,
   input  wire logic [12:0] src_enable,
   input  wire logic        top_level_pin_event,
   input  wire logic        trap_req,
   input  wire logic        insn_boundary,
   input  wire logic        stack_done,
   input  wire logic        return_from_handler,
   input  wire logic [7:0]  popped_cc,
   input  wire logic [7:0]  cc_write_data,
   input  wire logic        cc_write,
   output logic             service_start,
   output logic             stack_req,
   output logic             vector_load,
   output logic      [15:0] vector_addr,
   output logic      [3:0]  vector_index,
   output logic      [7:0]  condition_code_reg,
   output logic             level_bit_high,
   output logic             level_bit_low,
   output logic      [12:0] src_ack
);
   npic_pkg::npic_state_type state_r;
   npic_pkg::npic_state_type state_nxt;
   logic [7:0]  vector_priority_regs [0:3];
   logic [7:0]  cc_r;
   logic [7:0]  cc_nxt;
   logic        reset_pend_r;
   logic        tli_pend_r;
   logic        trap_pend_r;
   logic        tli_s1_r;
   logic        tli_s2_r;
   logic        tli_s3_r;
   logic [1:0]  win_code_r;
   logic [3:0]  win_idx_r;
   logic [15:0] win_vec_r;
   logic        win_nmi_r;
   logic        win_reset_r;
   logic [12:0] ack_nxt;
   logic        ack_pulse_r;
   logic        rd_pend_r;
   logic [31:0] rd_data_r;

   // Register slave: reads and writes both answer one cycle later, after one wait cycle
   wire         rd_wait    = avs_read & ~rd_pend_r;
   wire [25:0]  prio_flat  = {vector_priority_regs[3][1:0], vector_priority_regs[2],
                              vector_priority_regs[1], vector_priority_regs[0]};
   wire [1:0]   cur_level  = {cc_r[npic_pkg::CC_BIT_HIGH], cc_r[npic_pkg::CC_BIT_LOW]};

   // Synchronised rising edge of the top-level pin
   wire         tli_edge   = tli_s2_r & tli_s3_r & 1'b0 | (tli_s2_r & ~tli_s3_r);

   // Merge field writes, keeping any field written with the level-0 code
   function automatic logic [7:0] merge_prio(input logic [7:0] old_v, input logic [7:0] new_v);
      logic [7:0] res;
      res = old_v;
      for (int f = 0; f < 4; f++) begin
         if (new_v[2*f +: 2] != npic_pkg::CODE_L0) begin
            res[2*f +: 2] = new_v[2*f +: 2];
         end
      end
      return res;
   endfunction

   // Arbitration: software rank first, lower index is higher hardware priority
   logic [1:0]  best_rank;
   logic [3:0]  best_idx;
   logic        best_ok;
   always_comb begin
      best_rank = 2'h0;
      best_idx  = npic_pkg::IDX_NONE;
      best_ok   = 1'b0;
      for (int i = npic_pkg::NUM_SRC - 1; i >= 0; i--) begin
         // Requests stay pending on the source side until acknowledged
         if (src_req[i] && src_enable[i] &&
             npic_pkg::rank(prio_flat[2*i +: 2]) > npic_pkg::rank(cur_level) &&
             (!best_ok || npic_pkg::rank(prio_flat[2*i +: 2]) >= best_rank)) begin
            best_ok   = 1'b1;
            best_rank = npic_pkg::rank(prio_flat[2*i +: 2]);
            best_idx  = 4'(i);
         end
      end
   end

   wire         take_reset = reset_pend_r;
   wire         take_trap  = trap_pend_r & ~reset_pend_r;
   wire         take_tli   = tli_pend_r & ~reset_pend_r;
   wire         any_take   = take_reset | take_trap | take_tli | best_ok;
   wire         start      = (state_r == npic_pkg::NPIC_IDLE) & insn_boundary & any_take;

   // Priority of winners: reset, top-level pin (may interrupt trap), trap, maskables
   wire [3:0]   sel_idx    = take_reset ? npic_pkg::IDX_RESET :
                             take_tli   ? npic_pkg::IDX_TLI   :
                             take_trap  ? npic_pkg::IDX_TRAP  : best_idx;
   wire [15:0]  sel_vec    = take_reset ? npic_pkg::VEC_RESET :
                             take_tli   ? npic_pkg::VEC_TLI   :
                             take_trap  ? npic_pkg::VEC_TRAP  :
                             16'(npic_pkg::VEC_SRC0 - {11'h000, best_idx, 1'b0});
   wire         sel_nmi    = take_reset | take_tli | take_trap;
   wire [1:0]   sel_code   = sel_nmi ? npic_pkg::CODE_L3 : prio_flat[2*best_idx +: 2];
   wire         win_reset_sel = take_reset;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         npic_pkg::NPIC_IDLE: begin
            if (start) begin
               state_nxt = win_reset_sel ? npic_pkg::NPIC_LEVEL : npic_pkg::NPIC_STACK;
            end else if (return_from_handler) begin
               state_nxt = npic_pkg::NPIC_RETURN;
            end
         end
         npic_pkg::NPIC_STACK:  if (stack_done) state_nxt = npic_pkg::NPIC_LEVEL;
         npic_pkg::NPIC_LEVEL:  state_nxt = npic_pkg::NPIC_VECTOR;
         npic_pkg::NPIC_VECTOR: state_nxt = npic_pkg::NPIC_IDLE;
         npic_pkg::NPIC_RETURN: state_nxt = npic_pkg::NPIC_IDLE;
      endcase
   end

   always_comb begin
      cc_nxt = cc_r;
      if (state_r == npic_pkg::NPIC_LEVEL) begin
         cc_nxt[npic_pkg::CC_BIT_HIGH] = win_code_r[1];
         cc_nxt[npic_pkg::CC_BIT_LOW]  = win_code_r[0];
      end else if (state_r == npic_pkg::NPIC_RETURN) begin
         cc_nxt = popped_cc;
      end else if (cc_write) begin
         cc_nxt = cc_write_data;
      end
   end

   always_comb begin
      ack_nxt = 13'h0000;
      if (state_r == npic_pkg::NPIC_VECTOR && !win_nmi_r) begin
         ack_nxt[win_idx_r] = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r      <= npic_pkg::NPIC_IDLE;
         cc_r         <= npic_pkg::CC_RESET;
         reset_pend_r <= 1'b1;
         tli_pend_r   <= 1'b0;
         trap_pend_r  <= 1'b0;
         tli_s1_r     <= 1'b0;
         tli_s2_r     <= 1'b0;
         tli_s3_r     <= 1'b0;
         win_code_r   <= npic_pkg::CODE_L3;
         win_idx_r    <= npic_pkg::IDX_NONE;
         win_vec_r    <= npic_pkg::VEC_RESET;
         win_nmi_r    <= 1'b0;
         win_reset_r  <= 1'b0;
         ack_pulse_r  <= 1'b0;
         src_ack      <= 13'h0000;
      end else begin
         state_r     <= state_nxt;
         cc_r        <= cc_nxt;
         tli_s1_r    <= top_level_pin_event;
         tli_s2_r    <= tli_s1_r;
         tli_s3_r    <= tli_s2_r;
         src_ack     <= ack_nxt;
         ack_pulse_r <= |ack_nxt;
         if (start) begin
            win_code_r  <= sel_code;
            win_idx_r   <= sel_idx;
            win_vec_r   <= sel_vec;
            win_nmi_r   <= sel_nmi;
            win_reset_r <= take_reset;
         end
         // New events win over the clear of their pending flag
         if (start && take_reset) reset_pend_r <= 1'b0;
         tli_pend_r  <= tli_edge | (tli_pend_r & ~(start & take_tli));
         trap_pend_r <= trap_req | (trap_pend_r & ~(start & take_trap & ~take_tli));
      end
   end

   // Top register keeps its unused upper fields at ones
   wire [7:0]   merged3    = merge_prio(vector_priority_regs[3], avs_writedata[7:0]);

   // Write lands only at the acknowledging edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int r = 0; r < 4; r++) vector_priority_regs[r] <= npic_pkg::PRIO_RESET;
      end else if (avs_write && !avs_waitrequest) begin
         vector_priority_regs[avs_address] <= (avs_address == 2'h3) ?
            {4'hF, merged3[3:0]} :
            merge_prio(vector_priority_regs[avs_address], avs_writedata[7:0]);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_pend_r <= 1'b0;
         rd_data_r <= 32'h0000_0000;
      end else begin
         rd_pend_r <= rd_wait;
         if (rd_wait) rd_data_r <= {24'h000000, vector_priority_regs[avs_address]};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         service_start      <= 1'b0;
         stack_req          <= 1'b0;
         vector_load        <= 1'b0;
         vector_addr        <= npic_pkg::VEC_RESET;
         vector_index       <= npic_pkg::IDX_NONE;
         condition_code_reg <= npic_pkg::CC_RESET;
         level_bit_high     <= 1'b1;
         level_bit_low      <= 1'b1;
         avs_readdata       <= 32'h0000_0000;
         avs_waitrequest    <= 1'b1;
      end else begin
         service_start      <= start;
         stack_req          <= state_nxt == npic_pkg::NPIC_STACK;
         vector_load        <= state_r == npic_pkg::NPIC_LEVEL;
         vector_addr        <= start ? sel_vec : win_vec_r;
         vector_index       <= start ? sel_idx : win_idx_r;
         condition_code_reg <= cc_nxt;
         level_bit_high     <= cc_nxt[npic_pkg::CC_BIT_HIGH];
         level_bit_low      <= cc_nxt[npic_pkg::CC_BIT_LOW];
         avs_readdata       <= rd_wait ? {24'h000000, vector_priority_regs[avs_address]} :
                                         rd_data_r;
         avs_waitrequest    <= ~(rd_wait | (avs_write & avs_waitrequest));
      end
   end

   // Assertions
   a_level_load: assert property (@(posedge clk) disable iff (rst)
      state_r == npic_pkg::NPIC_LEVEL |=> {cc_r[5], cc_r[3]} == win_code_r)
      else $error("level bits not loaded from winner");
   a_nmi_level3: assert property (@(posedge clk) disable iff (rst)
      state_r == npic_pkg::NPIC_LEVEL && win_nmi_r |=> {cc_r[5], cc_r[3]} == 2'h3)
      else $error("non-maskable entry did not set level 3");
   sequence s_entry;
      state_r == npic_pkg::NPIC_LEVEL ##1 state_r == npic_pkg::NPIC_VECTOR;
   endsequence
   a_vector_after: assert property (@(posedge clk) disable iff (rst)
      s_entry |-> vector_load)
      else $error("vector load missing after level update");
   a_return_pop: assert property (@(posedge clk) disable iff (rst)
      state_r == npic_pkg::NPIC_RETURN |=> cc_r == $past(popped_cc))
      else $error("return did not restore condition code");
   a_boundary_only: assert property (@(posedge clk) disable iff (rst)
      start |-> insn_boundary)
      else $error("service started mid-instruction");
   a_mask_level: assert property (@(posedge clk) disable iff (rst)
      start && !sel_nmi |-> npic_pkg::rank(sel_code) > npic_pkg::rank(cur_level))
      else $error("maskable taken at or below level");
   a_reset_nostack: assert property (@(posedge clk) disable iff (rst)
      start && take_reset |=> state_r == npic_pkg::NPIC_LEVEL)
      else $error("reset entry stacked context");
   a_vec_range: assert property (@(posedge clk) disable iff (rst)
      start |-> sel_vec >= npic_pkg::VEC_BASE && sel_vec[0] == 1'b0)
      else $error("vector outside top table");
   a_prio_keep0: assert property (@(posedge clk) disable iff (rst)
      avs_write && avs_writedata[1:0] == 2'h2 |=>
      vector_priority_regs[$past(avs_address)][1:0] ==
      $past(vector_priority_regs[avs_address][1:0]))
      else $error("level-0 code was stored");

   // Bus handshake: one low cycle per access
   a_wait_write: assert property (@(posedge clk) disable iff (rst)
      avs_write && avs_waitrequest |=> !avs_waitrequest)
      else $error("write not acknowledged");

   a_wait_single: assert property (@(posedge clk) disable iff (rst)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("acknowledge longer than one cycle");

   a_read_upper: assert property (@(posedge clk) disable iff (rst)
      avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");

   a_reg3_top: assert property (@(posedge clk) disable iff (rst)
      vector_priority_regs[3][7:4] == 4'hF)
      else $error("unused priority fields changed");

   // Start and vector-load strobes are single pulses; the stacking request drops after done
   a_start_pulse: assert property (@(posedge clk) disable iff (rst)
      service_start |=> !service_start)
      else $error("service start longer than one cycle");

   a_load_pulse: assert property (@(posedge clk) disable iff (rst)
      vector_load |=> !vector_load)
      else $error("vector load longer than one cycle");

   a_stack_end: assert property (@(posedge clk) disable iff (rst)
      stack_req && stack_done |=> !stack_req)
      else $error("stacking request held after done");

   a_ack_onehot: assert property (@(posedge clk) disable iff (rst)
      $onehot0(src_ack) && ack_pulse_r == |src_ack)
      else $error("more than one source acknowledged");

   a_ack_pulse: assert property (@(posedge clk) disable iff (rst)
      |src_ack |=> src_ack == 13'h0000)
      else $error("acknowledge longer than one cycle");

   // Level outputs mirror the code register
   a_level_mirror: assert property (@(posedge clk) disable iff (rst)
      level_bit_high == condition_code_reg[5] && level_bit_low == condition_code_reg[3])
      else $error("level outputs differ from code register");

   a_cc_mirror: assert property (@(posedge clk) disable iff (rst)
      condition_code_reg == cc_r)
      else $error("code register output stale");

   // Winner selection
   a_mask_nol0: assert property (@(posedge clk) disable iff (rst)
      start && !sel_nmi |-> sel_code != npic_pkg::CODE_L0)
      else $error("maskable winner at main level");

   a_nmi_index: assert property (@(posedge clk) disable iff (rst)
      start && sel_nmi |-> sel_idx >= npic_pkg::IDX_TLI)
      else $error("non-maskable winner with source index");

   a_pin_first: assert property (@(posedge clk) disable iff (rst)
      start && take_tli |-> sel_vec == npic_pkg::VEC_TLI)
      else $error("pin event lost arbitration");

   a_reset_nmi: assert property (@(posedge clk) disable iff (rst)
      state_r == npic_pkg::NPIC_LEVEL && win_reset_r |-> win_nmi_r)
      else $error("reset entry treated as maskable");

   // Pending trap survives until it is taken
   a_trap_keep: assert property (@(posedge clk) disable iff (rst)
      trap_pend_r && !(start && take_trap && !take_tli) |=> trap_pend_r)
      else $error("pending trap lost");

   a_return_idle: assert property (@(posedge clk) disable iff (rst)
      state_r == npic_pkg::NPIC_RETURN |=> state_r == npic_pkg::NPIC_IDLE)
      else $error("return did not finish");
endmodule // npic_ctrl

// file: test/npic_seq_model.sv
// Behavioural instruction sequencer facing the interrupt controller
`timescale 1ns/1ns
module npic_seq_model #(
   parameter int INSN_CYC  = 3,
   parameter int STACK_CYC = 5
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic run,
   input  wire logic stack_req,
   output logic      insn_boundary,
   output logic      stack_done
);
   int insn_cnt;
   int push_cnt;

   // No boundary while context is pushed: the core is busy stacking
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         insn_cnt <= 0;
         insn_boundary <= 1'b0;
      end else if (run && !stack_req) begin
         insn_cnt <= (insn_cnt == INSN_CYC - 1) ? 0 : insn_cnt + 1;
         insn_boundary <= (insn_cnt == INSN_CYC - 1);
      end else begin
         insn_boundary <= 1'b0;
      end
   end

   // Five bytes pushed, one per cycle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         push_cnt <= 0;
         stack_done <= 1'b0;
      end else begin
         push_cnt <= (stack_req && !stack_done) ? push_cnt + 1 : 0;
         stack_done <= stack_req && !stack_done && push_cnt == STACK_CYC - 1;
      end
   end
endmodule // npic_seq_model

// file: test/test_nested_priority_interrupt_ctrl.sv
// Self-checking bench for the nested priority interrupt controller
`timescale 1ns/1ns
module test_nested_priority_interrupt_ctrl;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  avs_address = 2'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [12:0] src_req = 13'h0;
   logic [12:0] src_enable = 13'h1FFF;
   logic        top_level_pin_event = 1'b0;
   logic        trap_req = 1'b0;
   logic        run = 1'b0;
   logic        return_from_handler = 1'b0;
   logic [7:0]  popped_cc = 8'h0;
   logic [7:0]  cc_write_data = 8'h0;
   logic        cc_write = 1'b0;
   logic [31:0] avs_readdata;
   logic [15:0] vector_addr;
   logic [7:0]  condition_code_reg;
   logic [3:0]  vector_index;
   logic [12:0] src_ack;
   logic        avs_waitrequest, insn_boundary, stack_done, service_start, stack_req;
   logic        vector_load, level_bit_high, level_bit_low;
   int          bad_count = 0, n_tests = 0, n_start = 0, n_vl = 0, n_sr = 0;
   int          used_ss = 0, used_vl = 0, last_sr = 0;

   always #2 clk = ~clk;

   npic_ctrl DUT (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .src_req, .src_enable, .top_level_pin_event,
      .trap_req, .insn_boundary, .stack_done, .return_from_handler, .popped_cc,
      .cc_write_data, .cc_write, .service_start, .stack_req, .vector_load, .vector_addr,
      .vector_index, .condition_code_reg, .level_bit_high, .level_bit_low, .src_ack);

   npic_seq_model #(.INSN_CYC(3), .STACK_CYC(5)) seq (.clk, .rst, .run, .stack_req,
      .insn_boundary, .stack_done);

   // Pulses are counted so that no short pulse slips past a waiting task
   always @(posedge clk) begin
      n_start <= n_start + int'(service_start);
      n_vl <= n_vl + int'(vector_load);
      n_sr <= n_sr + int'(stack_req);
   end

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask

   task automatic bus(input logic we, input logic [1:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int k;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= we;
      avs_read <= ~we;
      k = 0;
      do begin
         tick(1);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      chk(32'(k < 50), 32'h1);
      q = avs_readdata;
      @(posedge clk);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdchk(input logic [1:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h0, q);
      chk(q, {24'h0, e});
   endtask

   // sw high: software write of the code register, low: handler return
   task automatic set_cc(input logic sw, input logic [7:0] v);
      @(posedge clk);
      cc_write <= sw;
      return_from_handler <= ~sw;
      cc_write_data <= v;
      popped_cc <= v;
      @(posedge clk);
      cc_write <= 1'b0;
      return_from_handler <= 1'b0;
      tick(1);
      chk({24'h0, condition_code_reg}, {24'h0, v});
   endtask

   task automatic no_entry(input int n);
      int b;
      b = n_start;
      tick(n);
      chk(n_start, b);
   endtask

   task automatic wait_vec(input logic [15:0] va, input logic [1:0] lvl, input int src,
                           input logic stk);
      int k;
      k = 0;
      while (n_start == used_ss && k < 80) begin
         tick(1);
         k++;
      end
      chk(32'(k < 80), 32'h1);
      used_ss++;
      if (src >= 0) begin
         @(posedge clk);
         src_req[src] <= 1'b0;
      end
      k = 0;
      while (n_vl == used_vl && k < 80) begin
         tick(1);
         k++;
      end
      chk(32'(k < 80), 32'h1);
      used_vl++;
      // Looked at in the acknowledge cycle, before a next entry can move the vector
      chk({16'h0, vector_addr}, {16'h0, va});
      if (src < 0) chk({28'h0, vector_index}, {28'h0, 2'h3, va[2:1]});
      else chk({31'h0, src_ack[src]}, 32'h1);
      chk({28'h0, level_bit_high, level_bit_low, condition_code_reg[5],
           condition_code_reg[3]}, {28'h0, lvl, lvl});
      chk({31'h0, n_sr != last_sr}, {31'h0, stk});
      last_sr = n_sr;
   endtask

   task automatic t_reset();
      chk({16'h0, vector_addr}, 32'hFFFE);
      for (int i = 0; i < 4; i++) rdchk(2'(i), 8'hFF);
      no_entry(10);
      @(posedge clk);
      run <= 1'b1;
      wait_vec(16'hFFFE, 2'h3, -1, 1'b0);
   endtask

   task automatic t_prio();
      wr(2'h1, 8'hCF);
      wr(2'h1, 8'h64);
      rdchk(2'h1, 8'h44);
      wr(2'h3, 8'h00);
      rdchk(2'h3, 8'hF0);
      wr(2'h0, 8'h11);
      wr(2'h1, 8'hDC);
   endtask

   task automatic t_nest();
      set_cc(1'b1, 8'hE2);
      @(posedge clk);
      src_enable[2] <= 1'b0;
      src_req[2] <= 1'b1;
      no_entry(20);
      @(posedge clk);
      src_enable[2] <= 1'b1;
      wait_vec(16'hFFF4, 2'h1, 2, 1'b1);
      @(posedge clk);
      src_req[0] <= 1'b1;
      no_entry(20);
      @(posedge clk);
      src_req[1] <= 1'b1;
      wait_vec(16'hFFF6, 2'h0, 1, 1'b1);
      set_cc(1'b0, 8'hC8);
      no_entry(20);
      set_cc(1'b0, 8'hE2);
      wait_vec(16'hFFF8, 2'h1, 0, 1'b1);
      set_cc(1'b0, 8'hE2);
   endtask

   task automatic t_arb();
      @(posedge clk);
      run <= 1'b0;
      src_req[6:3] <= 4'hF;
      tick(3);
      @(posedge clk);
      run <= 1'b1;
      wait_vec(16'hFFEE, 2'h3, 5, 1'b1);
      set_cc(1'b0, 8'hE2);
      wait_vec(16'hFFF2, 2'h0, 3, 1'b1);
      set_cc(1'b0, 8'hE2);
      wait_vec(16'hFFF0, 2'h0, 4, 1'b1);
      set_cc(1'b0, 8'hE2);
      wait_vec(16'hFFEC, 2'h1, 6, 1'b1);
      set_cc(1'b0, 8'hE2);
   endtask

   task automatic t_top();
      set_cc(1'b1, 8'hEA);
      @(posedge clk);
      run <= 1'b0;
      trap_req <= 1'b1;
      top_level_pin_event <= 1'b1;
      src_req[3] <= 1'b1;
      @(posedge clk);
      trap_req <= 1'b0;
      tick(4);
      @(posedge clk);
      run <= 1'b1;
      wait_vec(16'hFFFA, 2'h3, -1, 1'b1);
      wait_vec(16'hFFFC, 2'h3, -1, 1'b1);
      set_cc(1'b0, 8'hE2);
      wait_vec(16'hFFF2, 2'h0, 3, 1'b1);
   endtask

   initial begin
      tick(1);
      chk({24'h0, condition_code_reg}, 32'hEA);
      chk({31'h0, avs_waitrequest}, 32'h1);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_prio();
      t_nest();
      t_arb();
      t_top();
      give_verdict();
   end

   initial begin
      repeat (6000) @(posedge clk);
      bad_count++;
      give_verdict();
   end
endmodule // test_nested_priority_interrupt_ctrl
